/* core/tx_oob_params.svh */
// Offsets, field positions, reset values and nanosecond timings of the OOB transmit block.
`ifndef TX_OOB_PARAMS_SVH
`define TX_OOB_PARAMS_SVH
`define CLK_FREQ_MHZ        250
`define OOB_BURST_NS        107
`define OOB_GAP_INIT_NS     320
`define OOB_GAP_WAKE_NS     107
`define OOB_GAP_SAS_NS      480
`define NS_TO_CYCLES(ns)    ((((ns) * `CLK_FREQ_MHZ) + 999) / 1000)
`define REG_CONFIG          8'h00
`define REG_PWR_TIME        8'h04
`define REG_STATUS          8'h08
`define REG_IRQ_STATUS      8'h0C
`define REG_IRQ_MASK        8'h10
`define CFG_BURST_LSB       0
`define CFG_IDLE_ZERO_BIT   4
`define CFG_RATE_LSB        5
`define PWR_ENTRY_LSB       0
`define PWR_EXIT_LSB        16
`define CFG_RESET           32'h0000_0003
`define PWR_TIME_RESET      32'h0040_0040
`define IRQ_DONE_BIT        0
`define IRQ_POWER_BIT       1
`define IRQ_WIDTH           2
`define AXI_RESP_OKAY       2'h0
`define AXI_RESP_SLVERR     2'h2
`endif

/* core/tx_oob_pkg.sv */
// Types shared by the OOB transmit block.
package tx_oob_pkg;
   typedef enum logic [1:0] {COM_INIT, COM_WAKE, COM_SAS} com_kind_t;
   typedef enum logic [1:0] {PWR_P0, PWR_P0S, PWR_P1, PWR_P2} power_state_t;
   typedef enum logic [1:0] {RATE_FULL, RATE_HALF, RATE_QUARTER} rate_mode_t;
   typedef enum logic [1:0] {ENG_IDLE, ENG_BURST, ENG_GAP} eng_state_t;
   typedef struct packed {
      logic       electrical_idle;
      logic [1:0] power_code;
   } idle_pd_t;
endpackage

/* core/oob_burst_engine.sv */
// Burst and gap sequencer that emits N+1 bursts separated by gaps.
`timescale 1ns/100ps
module oob_burst_engine
   import tx_oob_pkg::*;
#(
   parameter int CW = 16
) (
   // Clock and reset.
   input  wire logic          aclk,
   input  wire logic          aresetn,
   // Control.
   input  wire logic          step,
   input  wire logic          start,
   input  wire logic [3:0]    bursts_minus_one,
   input  wire logic [CW-1:0] burst_cycles,
   input  wire logic [CW-1:0] gap_cycles,
   // Status.
   output logic               busy,
   output logic               burst_on,
   output logic               last_done
);
   eng_state_t    state;
   logic [CW-1:0] cnt;
   logic [3:0]    left;

   assign busy     = (state != ENG_IDLE);
   assign burst_on = (state == ENG_BURST);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state     <= ENG_IDLE;
         cnt       <= '0;
         left      <= '0;
         last_done <= 1'b0;
      end else begin
         last_done <= 1'b0;
         unique case (state)
            ENG_IDLE: begin
               if (start) begin
                  state <= ENG_BURST;
                  cnt   <= burst_cycles - 1'b1;
                  left  <= bursts_minus_one;
               end
            end
            ENG_BURST: begin
               if (step && cnt == '0) begin
                  if (left == 4'h0) begin
                     state     <= ENG_IDLE;
                     last_done <= 1'b1;
                  end else begin
                     state <= ENG_GAP;
                     cnt   <= gap_cycles - 1'b1;
                  end
               end else if (step) begin
                  cnt <= cnt - 1'b1;
               end
            end
            ENG_GAP: begin
               if (step && cnt == '0) begin
                  state <= ENG_BURST;
                  cnt   <= burst_cycles - 1'b1;
                  left  <= left - 1'b1;
               end else if (step) begin
                  cnt <= cnt - 1'b1;
               end
            end
            default: state <= ENG_IDLE;
         endcase
      end
   end
endmodule

/* core/tx_oob_com_sequence_generator.sv */
// Transmit OOB COM sequence generator with power-down handling and AXI4-Lite registers.
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "tx_oob_params.svh"
module tx_oob_com_sequence_generator
   import tx_oob_pkg::*;
#(
   parameter int DATA_W = 20,
   parameter int TIME_W = 16
) (
   // Clock and reset.
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite register port.
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // COM requests and completion.
   input  wire logic              send_init_sequence_req,
   input  wire logic              send_sas_sequence_req,
   input  wire logic              send_wake_sequence_req,
   output logic                   com_sequence_done,
   output logic                   com_busy,
   output logic                   oob_burst_out,
   // Idle and power-down.
   input  wire logic              idle_pd_async_select,
   input  wire logic              tx_electrical_idle,
   input  wire logic [1:0]        tx_power_state,
   output power_state_t           lane_power_state,
   output logic                   rx_detect_on,
   output logic                   lane_lowest_power,
   output logic                   power_transition_busy,
   // Data toward the serializer front end.
   input  wire logic [DATA_W-1:0] tx_data_in,
   output logic [DATA_W-1:0]      tx_data_out,
   // Rate and interrupt.
   output rate_mode_t             serial_ata_pll_rate_mode,
   output logic                   irq
);
   localparam logic [TIME_W-1:0] BURST_CYC =
      TIME_W'(`NS_TO_CYCLES(`OOB_BURST_NS));
   localparam logic [TIME_W-1:0] GAP_INIT_CYC =
      TIME_W'(`NS_TO_CYCLES(`OOB_GAP_INIT_NS));
   localparam logic [TIME_W-1:0] GAP_WAKE_CYC =
      TIME_W'(`NS_TO_CYCLES(`OOB_GAP_WAKE_NS));
   localparam logic [TIME_W-1:0] GAP_SAS_CYC =
      TIME_W'(`NS_TO_CYCLES(`OOB_GAP_SAS_NS));

   // Software registers.
   logic [31:0]            cfg_reg;
   logic [31:0]            pwr_time_reg;
   logic [`IRQ_WIDTH-1:0]  irq_status;
   logic [`IRQ_WIDTH-1:0]  irq_mask;

   wire  [3:0]        cfg_burst    = cfg_reg[`CFG_BURST_LSB +: 4];
   wire               cfg_idle_zero = cfg_reg[`CFG_IDLE_ZERO_BIT];
   wire  [1:0]        cfg_rate     = cfg_reg[`CFG_RATE_LSB +: 2];
   wire  [TIME_W-1:0] entry_time   = pwr_time_reg[`PWR_ENTRY_LSB +: TIME_W];
   wire  [TIME_W-1:0] exit_time    = pwr_time_reg[`PWR_EXIT_LSB +: TIME_W];

   // Rate decode and step divider.
   rate_mode_t next_rate;
   logic [1:0] div_cnt;
   logic       step;
   assign next_rate = (cfg_rate == 2'h1) ? RATE_HALF :
                      (cfg_rate == 2'h2) ? RATE_QUARTER : RATE_FULL;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_cnt                  <= 2'h0;
         step                     <= 1'b0;
         serial_ata_pll_rate_mode <= RATE_FULL;
      end else begin
         div_cnt                  <= div_cnt + 2'h1;
         serial_ata_pll_rate_mode <= next_rate;
         step <= (next_rate == RATE_FULL) ||
                 (next_rate == RATE_HALF && div_cnt[0]) ||
                 (next_rate == RATE_QUARTER && div_cnt == 2'h3);
      end
   end

   // Idle and power-down input capture, direct or through a synchroniser.
   idle_pd_t raw_in;
   idle_pd_t samp_q;
   idle_pd_t meta_q;
   idle_pd_t sync_q;
   idle_pd_t eff;
   logic     sel_meta;
   logic     sel_async;
   assign raw_in = '{electrical_idle: tx_electrical_idle, power_code: tx_power_state};
   assign eff    = sel_async ? sync_q : samp_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         samp_q    <= '0;
         meta_q    <= '0;
         sync_q    <= '0;
         sel_meta  <= 1'b0;
         sel_async <= 1'b0;
      end else begin
         samp_q    <= raw_in;
         meta_q    <= raw_in;
         sync_q    <= meta_q;
         sel_meta  <= idle_pd_async_select;
         sel_async <= sel_meta;
      end
   end

   // Power state decode and timed lowest-power transitions.
   power_state_t      pd_state;
   logic [1:0]        pd_last;
   logic [TIME_W-1:0] pwr_timer;
   logic              pwr_event;
   assign pd_state = (eff.power_code == 2'h0) ? PWR_P0 :
                     (eff.power_code == 2'h1) ? PWR_P0S :
                     (eff.power_code == 2'h2) ? PWR_P1 : PWR_P2;
   wire pd_change = (eff.power_code != pd_last);
   wire p2_move   = pd_change && (pd_state == PWR_P2 || pd_last == 2'h3);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pd_last               <= 2'h0;
         pwr_timer             <= '0;
         power_transition_busy <= 1'b0;
         lane_lowest_power     <= 1'b0;
         lane_power_state      <= PWR_P0;
         rx_detect_on          <= 1'b0;
         pwr_event             <= 1'b0;
      end else begin
         pd_last      <= eff.power_code;
         pwr_event    <= 1'b0;
         rx_detect_on <= (pd_state == PWR_P1);
         if (p2_move) begin
            power_transition_busy <= 1'b1;
            pwr_timer <= (pd_state == PWR_P2) ? entry_time : exit_time;
         end else if (power_transition_busy) begin
            if (pwr_timer == '0) begin
               power_transition_busy <= 1'b0;
               lane_lowest_power     <= (pd_state == PWR_P2);
               lane_power_state      <= pd_state;
               pwr_event             <= 1'b1;
            end else begin
               pwr_timer <= pwr_timer - 1'b1;
            end
         end else if (pd_change) begin
            lane_power_state <= pd_state;
         end
      end
   end

   // Data toward the serializer.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_data_out <= '0;
      end else begin
         tx_data_out <= (cfg_idle_zero && eff.electrical_idle) ? '0 : tx_data_in;
      end
   end

   // Request arbitration; a request seen while a sequence runs is ignored.
   com_kind_t         cur_kind;
   com_kind_t         req_kind;
   logic              eng_busy;
   logic              eng_burst;
   logic              eng_done;
   logic [TIME_W-1:0] gap_sel;
   wire any_req = send_init_sequence_req || send_sas_sequence_req ||
                  send_wake_sequence_req;
   wire start   = any_req && !eng_busy;
   assign req_kind = send_init_sequence_req ? COM_INIT :
                     send_wake_sequence_req ? COM_WAKE : COM_SAS;
   assign gap_sel  = (cur_kind == COM_INIT) ? GAP_INIT_CYC :
                     (cur_kind == COM_WAKE) ? GAP_WAKE_CYC : GAP_SAS_CYC;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cur_kind          <= COM_INIT;
         com_sequence_done <= 1'b0;
         com_busy          <= 1'b0;
         oob_burst_out     <= 1'b0;
      end else begin
         if (start) begin
            cur_kind <= req_kind;
         end
         com_sequence_done <= eng_done;
         com_busy          <= eng_busy;
         oob_burst_out     <= eng_burst;
      end
   end

   oob_burst_engine #(
      .CW (TIME_W)
   ) u_engine (
      .aclk             (aclk),
      .aresetn          (aresetn),
      .step             (step),
      .start            (start),
      .bursts_minus_one (cfg_burst),
      .burst_cycles     (BURST_CYC),
      .gap_cycles       (gap_sel),
      .busy             (eng_busy),
      .burst_on         (eng_burst),
      .last_done        (eng_done)
   );

   // AXI4-Lite slave.
   logic              aw_got;
   logic              w_got;
   logic [7:0]        aw_addr;
   logic [31:0]       w_data;
   logic [3:0]        w_strb;
   logic [31:0]       byte_mask;
   logic [31:0]       rd_mux;
   logic [`IRQ_WIDTH-1:0] irq_clear;
   logic [`IRQ_WIDTH-1:0] irq_set;

   for (genvar b = 0; b < 4; b++) begin : g_mask
      assign byte_mask[8*b +: 8] = {8{w_strb[b]}};
   end

   wire do_write = aw_got && w_got && !s_axi_bvalid;
   wire wr_cfg   = do_write && aw_addr == `REG_CONFIG;
   wire wr_pwr   = do_write && aw_addr == `REG_PWR_TIME;
   wire wr_ista  = do_write && aw_addr == `REG_IRQ_STATUS;
   wire wr_imask = do_write && aw_addr == `REG_IRQ_MASK;
   wire wr_hit   = wr_cfg || wr_pwr || wr_ista || wr_imask;
   wire [31:0] wmerge_cfg = (cfg_reg & ~byte_mask) | (w_data & byte_mask);
   wire [31:0] wmerge_pwr = (pwr_time_reg & ~byte_mask) | (w_data & byte_mask);
   wire rd_hit = (s_axi_araddr == `REG_CONFIG) || (s_axi_araddr == `REG_PWR_TIME) ||
                 (s_axi_araddr == `REG_STATUS) || (s_axi_araddr == `REG_IRQ_STATUS) ||
                 (s_axi_araddr == `REG_IRQ_MASK);
   wire [31:0] status_word = {26'h0, lane_lowest_power, power_transition_busy,
                              eff.power_code, eff.electrical_idle, com_busy};

   assign irq_clear = wr_ista ? (w_data[`IRQ_WIDTH-1:0] & byte_mask[`IRQ_WIDTH-1:0])
                              : '0;
   assign irq_set   = {pwr_event, eng_done};
   assign rd_mux = (s_axi_araddr == `REG_CONFIG)     ? cfg_reg :
                   (s_axi_araddr == `REG_PWR_TIME)   ? pwr_time_reg :
                   (s_axi_araddr == `REG_STATUS)     ? status_word :
                   (s_axi_araddr == `REG_IRQ_STATUS) ? {30'h0, irq_status} :
                   (s_axi_araddr == `REG_IRQ_MASK)   ? {30'h0, irq_mask} : 32'h0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `AXI_RESP_OKAY;
         aw_got        <= 1'b0;
         w_got         <= 1'b0;
         aw_addr       <= 8'h00;
         w_data        <= 32'h0;
         w_strb        <= 4'h0;
      end else begin
         s_axi_awready <= !aw_got && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !w_got && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got  <= 1'b1;
            aw_addr <= {s_axi_awaddr[7:2], 2'h0};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got  <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= `AXI_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_mux;
         s_axi_rresp   <= rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

   // Register storage; a status set in the clearing cycle wins.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_reg      <= `CFG_RESET;
         pwr_time_reg <= `PWR_TIME_RESET;
         irq_status   <= '0;
         irq_mask     <= '0;
         irq          <= 1'b0;
      end else begin
         if (wr_cfg) cfg_reg <= wmerge_cfg;
         if (wr_pwr) pwr_time_reg <= wmerge_pwr;
         if (wr_imask) irq_mask <= w_data[`IRQ_WIDTH-1:0];
         irq_status <= (irq_status & ~irq_clear) | irq_set;
         irq        <= |(((irq_status & ~irq_clear) | irq_set) & irq_mask);
      end
   end

   // Checks.
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   logic [4:0] bursts_seen;
   logic [3:0] len_at_start;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bursts_seen  <= 5'h0;
         len_at_start <= 4'h0;
      end else if (start) begin
         bursts_seen  <= 5'h0;
         len_at_start <= cfg_burst;
      end else if (eng_burst && !oob_burst_out) begin
         bursts_seen <= bursts_seen + 5'h1;
      end
   end

   a_init_starts: assert property (start && send_init_sequence_req
      |=> cur_kind == COM_INIT ##1 oob_burst_out) else $error("init burst missing");
   a_sas_starts: assert property (start && req_kind == COM_SAS
      |=> cur_kind == COM_SAS ##1 oob_burst_out) else $error("sas burst missing");
   a_wake_starts: assert property (start && req_kind == COM_WAKE
      |=> cur_kind == COM_WAKE ##1 oob_burst_out) else $error("wake burst missing");
   a_done_after_burst: assert property (com_sequence_done
      |-> !oob_burst_out && $past(oob_burst_out)) else $error("done not at burst end");
   a_burst_count: assert property (eng_done
      |-> bursts_seen == {1'b0, len_at_start} + 5'h1) else $error("wrong burst count");
   a_sync_capture: assert property (!sel_async && $past(!sel_async)
      |-> eff.electrical_idle == $past(tx_electrical_idle)) else $error("sync path");
   a_async_capture: assert property (sel_async && $past(sel_async)
      |-> eff.power_code == $past(tx_power_state, 2)) else $error("async path");
   a_detect_decode: assert property (eff.power_code == 2'h2
      |=> rx_detect_on) else $error("P1 detect not on");
   a_lowest_timed: assert property ($rose(lane_lowest_power)
      |-> $past(power_transition_busy) && $past(pwr_timer) == '0) else $error("P2 early");
   a_idle_zero: assert property (cfg_idle_zero && eff.electrical_idle
      |=> tx_data_out == '0) else $error("idle data not zero");
   // The rate must stay at quarter over the whole window, or a rate change lets step rise early.
   a_quarter_step: assert property (step && next_rate == RATE_QUARTER && $stable(cfg_rate)
      ##1 next_rate == RATE_QUARTER [*2]
      |-> !step && !$past(step) ##1 !step) else $error("quarter rate step");

   c_init_done: cover property (cur_kind == COM_INIT && com_sequence_done);
   c_sas_done: cover property (cur_kind == COM_SAS && com_sequence_done);
   c_wake_done: cover property (cur_kind == COM_WAKE && com_sequence_done);
   c_lowest_power: cover property ($rose(lane_lowest_power));
endmodule

/* bench/fabric_com_driver.sv */
// Fabric-side model that raises one COM request at a time.
`timescale 1ns/100ps
module fabric_com_driver
   import tx_oob_pkg::*;
(
   // Clock and reset.
   input  wire logic      aclk,
   input  wire logic      aresetn,
   // Command from the bench and status of the block.
   input  wire logic      go,
   input  wire com_kind_t kind,
   input  wire logic      com_busy,
   // Requests toward the block.
   output logic           send_init_sequence_req,
   output logic           send_sas_sequence_req,
   output logic           send_wake_sequence_req
);
   // The request is dropped once the sequence runs, so it cannot retrigger after done.
   always_ff @(posedge aclk) begin
      if (!aresetn || com_busy) begin
         send_init_sequence_req <= 1'b0;
         send_sas_sequence_req  <= 1'b0;
         send_wake_sequence_req <= 1'b0;
      end else if (go) begin
         send_init_sequence_req <= (kind == COM_INIT);
         send_sas_sequence_req  <= (kind == COM_SAS);
         send_wake_sequence_req <= (kind == COM_WAKE);
      end
   end
endmodule

/* bench/tb.sv */
// Self-checking bench for the OOB transmit block.
`timescale 1ns/100ps
`include "tx_oob_params.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
   $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module tb
   import tx_oob_pkg::*;
;
   logic         aclk = 1'b0, aresetn = 1'b0, go = 1'b0;
   com_kind_t    kind = COM_INIT;
   logic [7:0]   s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0]  s_axi_wdata = 32'h0, s_axi_rdata;
   logic         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]   s_axi_bresp, s_axi_rresp, tx_power_state = 2'h0;
   logic         send_init_sequence_req, send_sas_sequence_req, send_wake_sequence_req;
   logic         com_sequence_done, com_busy, oob_burst_out, rx_detect_on, irq;
   logic         idle_pd_async_select = 1'b0, tx_electrical_idle = 1'b0;
   logic         lane_lowest_power, power_transition_busy;
   logic [19:0]  tx_data_in = 20'h0, tx_data_out;
   power_state_t lane_power_state;
   rate_mode_t   serial_ata_pll_rate_mode;
   int           errors = 0, n_checks = 0, r, n;
   initial forever #2 aclk = ~aclk;
   fabric_com_driver u_fab (.aclk(aclk), .aresetn(aresetn), .go(go), .kind(kind),
      .com_busy(com_busy), .send_init_sequence_req(send_init_sequence_req),
      .send_sas_sequence_req(send_sas_sequence_req),
      .send_wake_sequence_req(send_wake_sequence_req));
   tx_oob_com_sequence_generator u_dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .send_init_sequence_req(send_init_sequence_req),
      .send_sas_sequence_req(send_sas_sequence_req),
      .send_wake_sequence_req(send_wake_sequence_req), .com_sequence_done(com_sequence_done),
      .com_busy(com_busy), .oob_burst_out(oob_burst_out),
      .idle_pd_async_select(idle_pd_async_select), .tx_electrical_idle(tx_electrical_idle),
      .tx_power_state(tx_power_state), .lane_power_state(lane_power_state),
      .rx_detect_on(rx_detect_on), .lane_lowest_power(lane_lowest_power),
      .power_transition_busy(power_transition_busy), .tx_data_in(tx_data_in),
      .tx_data_out(tx_data_out), .serial_ata_pll_rate_mode(serial_ata_pll_rate_mode), .irq(irq));
   task automatic results();
      if (errors == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic tmo();
      errors++;
      results();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int i;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      if (i == 100) tmo();
      `CHK("bresp", er, s_axi_bresp)
   endtask
   task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
      int i;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      if (i == 100) tmo();
      `CHK("rresp", er, s_axi_rresp)
      `CHK("rdata", ed, s_axi_rdata)
   endtask
   // Counts rising edges of the burst output until the done pulse.
   task automatic com(input com_kind_t k, input int nexp);
      int   i;
      int   cnt;
      logic prev;
      cnt = 0;
      prev = 1'b0;
      go <= 1'b1;
      kind <= k;
      @(posedge aclk);
      go <= 1'b0;
      for (i = 0; i < 5000; i++) begin
         @(posedge aclk);
         if (com_sequence_done === 1'b1) break;
         if (oob_burst_out === 1'b1 && !prev) cnt++;
         prev = (oob_burst_out === 1'b1);
      end
      if (i == 5000) tmo();
      `CHK("bursts", nexp, cnt)
      @(posedge aclk);
      `CHK("done pulse", 1'b0, com_sequence_done)
      `CHK("busy end", 1'b0, com_busy)
   endtask
   task automatic set_pwr(input logic [1:0] c, output int cyc);
      tx_power_state <= c;
      for (cyc = 0; cyc < 200; cyc++) begin
         @(posedge aclk);
         if (lane_power_state === power_state_t'(c) && power_transition_busy === 1'b0) break;
      end
      if (cyc == 200) tmo();
      `CHK("rx detect", (c == 2'h2), rx_detect_on)
      `CHK("lowest power", (c == 2'h3), lane_lowest_power)
   endtask
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(`REG_CONFIG, `AXI_RESP_OKAY, `CFG_RESET);
      rd(`REG_PWR_TIME, `AXI_RESP_OKAY, `PWR_TIME_RESET);
      rd(8'h20, `AXI_RESP_SLVERR, 32'h0);
      wr(8'h20, 32'h0000_00FF, `AXI_RESP_SLVERR);
      for (r = 0; r < 3; r++) begin
         wr(`REG_CONFIG, (r << `CFG_RATE_LSB) | r, `AXI_RESP_OKAY);
         repeat (2) @(posedge aclk);
         `CHK("rate", rate_mode_t'(r), serial_ata_pll_rate_mode)
         com(com_kind_t'(r), r + 1);
         if (r == 0) begin
            `CHK("irq masked", 1'b0, irq)
            wr(`REG_IRQ_MASK, 32'h1, `AXI_RESP_OKAY);
            repeat (2) @(posedge aclk);
            `CHK("irq", 1'b1, irq)
            rd(`REG_IRQ_STATUS, `AXI_RESP_OKAY, 32'h1);
            wr(`REG_IRQ_STATUS, 32'h1, `AXI_RESP_OKAY);
            repeat (2) @(posedge aclk);
            `CHK("irq cleared", 1'b0, irq)
         end
      end
      wr(`REG_CONFIG, 32'h0000_0010, `AXI_RESP_OKAY);
      tx_data_in <= 20'hA5A5A;
      tx_electrical_idle <= 1'b1;
      repeat (4) @(posedge aclk);
      `CHK("idle data", 20'h0, tx_data_out)
      tx_electrical_idle <= 1'b0;
      repeat (4) @(posedge aclk);
      `CHK("live data", 20'hA5A5A, tx_data_out)
      wr(`REG_PWR_TIME, 32'h0004_0004, `AXI_RESP_OKAY);
      set_pwr(2'h1, n);
      set_pwr(2'h2, n);
      set_pwr(2'h3, n);
      `CHK("entry time", 1'b1, n > 4)
      rd(`REG_STATUS, `AXI_RESP_OKAY, 32'h0000_002C);
      rd(`REG_IRQ_STATUS, `AXI_RESP_OKAY, 32'h3);
      idle_pd_async_select <= 1'b1;
      repeat (4) @(posedge aclk);
      set_pwr(2'h0, n);
      `CHK("exit time", 1'b1, n > 4)
      results();
   end
endmodule
